// [inc/tbr_pkg.sv]
// trace buffer readout: register map, field layout and carrier types
package tbr_pkg;

   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_FIRST_CTRL = 8'h20;
   localparam logic [7:0] IDX_STATUS = 8'h21;
   localparam logic [7:0] IDX_TRACE_CTRL = 8'h22;
   localparam logic [7:0] IDX_WINDOW_HIGH = 8'h24;
   localparam logic [7:0] IDX_WINDOW_LOW = 8'h25;
   localparam logic [7:0] IDX_LINE_COUNT = 8'h26;
   localparam logic [7:0] IDX_BANKED = 8'h27;

   // bus decode
   localparam int unsigned IDX_LSB = 2;
   localparam int unsigned IDX_MSB = 9;
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

   // field positions
   localparam int unsigned ARM_BIT = 7;
   localparam int unsigned BANK_LSB = 0;
   localparam int unsigned FULL_BIT = 7;
   localparam int unsigned SOURCE_BIT = 6;
   localparam int unsigned ALIGN_LSB = 0;

   // trigger alignment codes
   localparam logic [1:0] ALIGN_END = 2'h0;
   localparam logic [1:0] ALIGN_BEGIN = 2'h1;
   localparam logic [1:0] ALIGN_MIDDLE = 2'h2;

   // buffer geometry: 64 lines of 64 bits, read 16 bits at a time
   localparam int unsigned LINE_W = 64;
   localparam int unsigned LINES = 64;
   localparam int unsigned LINE_IDX_W = 6;
   localparam int unsigned PTR_W = 8;
   localparam int unsigned COUNT_W = 7;
   localparam int unsigned SC_W = 4;

   typedef enum logic [1:0] {
      BANK_STATE1 = 2'b00,
      BANK_STATE2 = 2'b01,
      BANK_STATE3 = 2'b10,
      BANK_MATCH = 2'b11
   } tbr_bank_t;

   typedef enum logic [1:0] {
      PH_IDLE = 2'b00,
      PH_WRITE = 2'b01,
      PH_READ_WAIT = 2'b10,
      PH_READ_DONE = 2'b11
   } tbr_phase_t;

   // capture side: one half line or one whole line per pulse
   typedef struct packed {
      logic half;
      logic line;
      logic [LINE_W-1:0] data;
   } tbr_cap_t;

   typedef struct packed {
      logic sec_meta;
      logic sec;
      logic armed;
      tbr_bank_t bank;
      logic source;
      logic [1:0] align;
      logic [SC_W-1:0] scr1;
      logic [SC_W-1:0] scr2;
      logic [SC_W-1:0] scr3;
      logic unlocked;
      logic full;
      logic [COUNT_W-1:0] count;
      logic [LINE_IDX_W-1:0] wr_line;
      logic [PTR_W-1:0] rd_ptr;
      tbr_phase_t phase;
      logic [7:0] dph_idx;
      logic dph_ok;
      logic [31:0] rdata;
   } tbr_state_t;

endpackage

// [src/tbr_readout.sv]
// trace buffer readout window, valid-line counter and banked state control
`timescale 1ns/100ps
`default_nettype none

module tbr_readout
   import tbr_pkg::*;
(
   // clock and power-on reset
   input wire logic hclk,
   input wire logic hresetn,
   // other system reset, one-cycle pulse on hclk
   input wire logic sys_reset_req,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // security pin, asynchronous
   input wire logic secure_pin,
   // capture side and comparator flags
   input wire tbr_cap_t cap,
   input wire logic [SC_W-1:0] match_flags,
   // state sequencer view
   output logic armed,
   output logic buffer_full_flag,
   output logic [SC_W-1:0] state1_next_control,
   output logic [SC_W-1:0] state2_next_control,
   output logic [SC_W-1:0] state3_next_control
);

   tbr_state_t q;
   tbr_state_t d;
   logic [LINE_W-1:0] mem_q [LINES];
   logic [LINE_W-1:0] line_word;
   logic [15:0] win_half;
   logic read_ok;
   logic wr_arm;
   logic unlock;
   logic cap_go;
   logic win_read;
   logic [COUNT_W-1:0] count_step;

   function automatic logic [SC_W-1:0] bank_view(input tbr_state_t s,
                                                 input logic [SC_W-1:0] mf);
      case (s.bank)
         BANK_STATE1: bank_view = s.scr1;
         BANK_STATE2: bank_view = s.scr2;
         BANK_STATE3: bank_view = s.scr3;
         default: bank_view = mf;
      endcase
   endfunction

   assign hreadyout = (q.phase != PH_READ_WAIT);
   assign hresp = 1'b0;
   assign hrdata = q.rdata;
   assign armed = q.armed;
   assign buffer_full_flag = q.full;
   assign state1_next_control = q.scr1;
   assign state2_next_control = q.scr2;
   assign state3_next_control = q.scr3;

   always_comb begin
      d = q;
      wr_arm = 1'b0;
      unlock = 1'b0;
      win_read = 1'b0;
      // second stage only reads the first
      d.sec_meta = secure_pin;
      d.sec = q.sec_meta;
      read_ok = q.unlocked & ~q.sec & ~q.armed & q.source;
      line_word = mem_q[q.rd_ptr[PTR_W-1:2]];
      win_half = line_word[{q.rd_ptr[1:0], 4'h0} +: 16];
      count_step = {6'(q.count[COUNT_W-1:1] + 6'h01), 1'b0};

      // data phase
      case (q.phase)
         PH_WRITE: begin
            d.phase = PH_IDLE;
            if (q.dph_ok) begin
               case (q.dph_idx)
                  IDX_FIRST_CTRL: begin
                     d.bank = tbr_bank_t'(hwdata[BANK_LSB +: 2]);
                     if (hwdata[ARM_BIT]) begin
                        wr_arm = 1'b1;
                     end else begin
                        d.armed = 1'b0;
                     end
                  end
                  IDX_TRACE_CTRL: begin
                     if (!q.armed) begin
                        d.align = hwdata[ALIGN_LSB +: 2];
                        // tracing cannot be selected on a secured part
                        d.source = hwdata[SOURCE_BIT] & ~q.sec;
                     end
                  end
                  IDX_WINDOW_HIGH: begin
                     unlock = ~q.armed;
                  end
                  IDX_BANKED: begin
                     if (!q.armed) begin
                        case (q.bank)
                           BANK_STATE1: d.scr1 = hwdata[SC_W-1:0];
                           BANK_STATE2: d.scr2 = hwdata[SC_W-1:0];
                           BANK_STATE3: d.scr3 = hwdata[SC_W-1:0];
                           default: ;
                        endcase
                     end
                  end
                  // the count register and status take no writes
                  default: ;
               endcase
            end
         end
         PH_READ_WAIT: begin
            // one wait state so a read sees any write just before it
            d.phase = PH_READ_DONE;
            d.rdata = 32'h0000_0000;
            if (q.dph_ok) begin
               case (q.dph_idx)
                  IDX_FIRST_CTRL: begin
                     d.rdata[ARM_BIT] = q.armed;
                     d.rdata[BANK_LSB +: 2] = q.bank;
                  end
                  IDX_STATUS: d.rdata[FULL_BIT] = q.full;
                  IDX_TRACE_CTRL: begin
                     d.rdata[SOURCE_BIT] = q.source;
                     d.rdata[ALIGN_LSB +: 2] = q.align;
                  end
                  IDX_LINE_COUNT: d.rdata[COUNT_W-1:0] = q.count;
                  IDX_BANKED: d.rdata[SC_W-1:0] = bank_view(q, match_flags);
                  IDX_WINDOW_HIGH: begin
                     if (read_ok) begin
                        win_read = 1'b1;
                        d.rdata[15:0] = win_half;
                        // the pointer moves, the count is left alone
                        d.rd_ptr = 8'(q.rd_ptr + 8'h01);
                     end
                  end
                  // low half alone has no read decode here and reads zero
                  default: ;
               endcase
            end
         end
         PH_READ_DONE: d.phase = PH_IDLE;
         default: d.phase = PH_IDLE;
      endcase

      // address phase
      if (hsel && hready && htrans == HTRANS_NONSEQ) begin
         d.phase = hwrite ? PH_WRITE : PH_READ_WAIT;
         d.dph_idx = haddr[IDX_MSB:IDX_LSB];
         // only aligned whole words reach a register
         d.dph_ok = (hsize == HSIZE_WORD) && (haddr[1:0] == 2'h0)
                    && (haddr[31:IDX_MSB+1] == '0);
      end

      // capture of new trace data
      cap_go = q.armed & cap.line & ~wr_arm & ~sys_reset_req;
      if (q.armed && cap.half && !cap.line) begin
         d.count[0] = 1'b1;
      end
      if (cap_go) begin
         d.wr_line = 6'(q.wr_line + 6'h01);
         d.count = count_step;
         if (count_step == '0) begin
            // except under begin alignment, which disarms here, newest lines overwrite the oldest from here on
            d.full = 1'b1;
            if (q.align == ALIGN_BEGIN) begin
               d.armed = 1'b0;
            end
         end
      end

      if (wr_arm) begin
         d.armed = 1'b1;
         d.unlocked = 1'b0;
         d.count = '0;
         d.full = 1'b0;
         d.wr_line = '0;
      end
      if (unlock) begin
         d.unlocked = 1'b1;
         d.rd_ptr = q.full ? {q.wr_line, 2'h0} : '0;
      end

      // other resets keep count, flag, pointers and contents
      if (sys_reset_req) begin
         d.armed = 1'b0;
         d.bank = BANK_STATE1;
         d.source = 1'b0;
         d.align = ALIGN_END;
         d.scr1 = '0;
         d.scr2 = '0;
         d.scr3 = '0;
         d.unlocked = 1'b0;
         d.phase = PH_IDLE;
         d.rdata = '0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // no reset: contents are undefined only after power-on
   always_ff @(posedge hclk) begin
      if (cap_go) begin
         mem_q[q.wr_line] <= cap.data;
      end
   end

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   a_arm_clears_count: assert property (
      wr_arm && !sys_reset_req |=> q.count == '0 && !q.full && q.armed && !q.unlocked)
      else $error("arming did not clear count and full flag");

   a_count_no_write: assert property (
      q.phase == PH_WRITE && q.dph_idx == IDX_LINE_COUNT && !q.armed && !cap.half
      |=> $stable(q.count))
      else $error("write changed the line count");

   a_bad_read_zero: assert property (
      q.phase == PH_READ_WAIT && q.dph_idx == IDX_WINDOW_HIGH && !q.dph_ok
      && !sys_reset_req |=> q.rdata == 32'h0000_0000 && $stable(q.rd_ptr))
      else $error("bad window read returned data or moved pointer");

   a_armed_read_zero: assert property (
      q.phase == PH_READ_WAIT && q.dph_idx == IDX_WINDOW_HIGH && q.armed
      && !sys_reset_req |=> q.rdata == 32'h0000_0000 && $stable(q.rd_ptr))
      else $error("armed window read returned data or moved pointer");

   a_ptr_advance: assert property (
      win_read && !sys_reset_req
      |=> q.rd_ptr == 8'($past(q.rd_ptr) + 8'h01) && q.rdata[31:16] == 16'h0000)
      else $error("valid read did not advance the pointer");

   a_unlock_rewind: assert property (
      unlock && !q.full && !sys_reset_req |=> q.unlocked && q.rd_ptr == '0)
      else $error("unlock did not rewind the pointer");

   a_wrap_sets_full: assert property (
      cap_go && q.count[COUNT_W-1:1] == 6'h3F && q.align != ALIGN_BEGIN
      && !(q.phase == PH_WRITE && q.dph_idx == IDX_FIRST_CTRL)
      |=> q.full && q.armed && q.count == '0)
      else $error("wrap did not set full or stopped counting");

   a_begin_ends: assert property (
      cap_go && q.count[COUNT_W-1:1] == 6'h3F && q.align == ALIGN_BEGIN
      |=> q.full && !q.armed && !cap_go)
      else $error("begin alignment did not end the session");

   a_read_keeps_count: assert property (
      win_read |=> $stable(q.count))
      else $error("window read altered the count");

   a_bank_view: assert property (
      q.phase == PH_READ_WAIT && q.dph_ok && q.dph_idx == IDX_BANKED
      && q.bank == BANK_STATE2 && !sys_reset_req |=> q.rdata[SC_W-1:0] == $past(q.scr2))
      else $error("banked read showed the wrong register");

   a_read_wait: assert property (
      q.phase == PH_READ_WAIT |-> !hreadyout ##1 hreadyout)
      else $error("read did not complete after one wait state");

   c_window_read: cover property (win_read ##[1:8] win_read);
   c_wrap_mid: cover property (cap_go && q.align == ALIGN_MIDDLE ##1 q.full);
   c_unlock_full: cover property (unlock && q.full);
   c_match_view: cover property (q.phase == PH_READ_WAIT && q.bank == BANK_MATCH);

endmodule // tbr_readout

`default_nettype wire

// [verification/tbr_readout_tb.sv]
// self-checking bench for the trace buffer readout block
`timescale 1ns/100ps
`default_nettype none
module tbr_readout_tb;
   import tbr_pkg::*;
   logic hclk, hresetn, sys_reset_req, hsel, hwrite, hreadyout, hresp, secure_pin, armed, full;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [SC_W-1:0] match_flags, sc1, sc2, sc3;
   tbr_cap_t cap;
   int fails, comparisons;

   // single slave, so its own ready closes the loop
   tbr_readout u_tbr_readout (
      .hclk(hclk), .hresetn(hresetn), .sys_reset_req(sys_reset_req),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .secure_pin(secure_pin), .cap(cap), .match_flags(match_flags),
      .armed(armed), .buffer_full_flag(full), .state1_next_control(sc1),
      .state2_next_control(sc2), .state3_next_control(sc3)
   );

   initial begin
      hclk = 1'b0;
      forever #2 hclk = ~hclk;
   end

   function automatic logic [63:0] ln(input int i);
      logic [7:0] n;
      n = 8'(i);
      return {n, 8'h03, n, 8'h02, n, 8'h01, n, 8'h00};
   endfunction

   function automatic logic [31:0] qv(input int i, input int q);
      return {16'h0000, 8'(i), 8'(q)};
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: got %08h expected %08h", $time, got, exp);
      end
   endtask

   // ready is looked at on the falling edge so the rising edge never races the design
   task automatic xfer(input logic wr, input logic [7:0] idx, input logic [2:0] sz,
                       input logic [1:0] off, input logic [31:0] wd);
      logic rdy;
      hsel <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      haddr <= {22'h000000, idx, off};
      hwrite <= wr;
      hsize <= sz;
      do begin
         @(negedge hclk);
         rdy = hreadyout;
         @(posedge hclk);
      end while (rdy !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do begin
         @(negedge hclk);
         rdy = hreadyout;
         rd = hrdata;
         @(posedge hclk);
      end while (rdy !== 1'b1);
   endtask

   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      xfer(1'b1, idx, HSIZE_WORD, 2'h0, d);
   endtask

   task automatic rx(input logic [7:0] idx, input logic [2:0] sz, input logic [1:0] off,
                     input logic [31:0] exp);
      xfer(1'b0, idx, sz, off, 32'h00000000);
      chk(rd, exp);
   endtask

   task automatic rc(input logic [7:0] idx, input logic [31:0] exp);
      rx(idx, HSIZE_WORD, 2'h0, exp);
   endtask

   task automatic push(input int first, input int n);
      for (int i = 0; i < n; i++) begin
         cap <= '{half: 1'b0, line: 1'b1, data: ln(first + i)};
         @(posedge hclk);
      end
      cap <= '0;
      @(posedge hclk);
   endtask

   task automatic final_report;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   initial begin
      #100000;
      fails++;
      final_report();
   end

   initial begin
      hresetn = 1'b0;
      sys_reset_req = 1'b0;
      hsel = 1'b0;
      haddr = 32'h00000000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = HSIZE_WORD;
      hwdata = 32'h00000000;
      secure_pin = 1'b0;
      cap = '0;
      match_flags = 4'h9;
      fails = 0;
      comparisons = 0;
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rc(IDX_LINE_COUNT, 32'h00000000);
      rc(IDX_STATUS, 32'h00000000);
      wr(IDX_LINE_COUNT, 32'h0000007F);
      rc(IDX_LINE_COUNT, 32'h00000000);
      wr(IDX_TRACE_CTRL, 32'h00000040);
      wr(IDX_FIRST_CTRL, 32'h00000080);
      cap <= '{half: 1'b1, line: 1'b0, data: 64'h0000000000000000};
      @(posedge hclk);
      cap <= '0;
      @(posedge hclk);
      rc(IDX_LINE_COUNT, 32'h00000001);
      push(0, 3);
      rc(IDX_LINE_COUNT, 32'h00000006);
      wr(IDX_WINDOW_HIGH, 32'h0000FFFF);
      rc(IDX_WINDOW_HIGH, 32'h00000000);
      wr(IDX_FIRST_CTRL, 32'h00000000);
      rc(IDX_WINDOW_HIGH, 32'h00000000);
      wr(IDX_WINDOW_HIGH, 32'h0000FFFF);
      for (int q = 0; q < 4; q++) begin
         rc(IDX_WINDOW_HIGH, qv(0, q));
      end
      rx(IDX_WINDOW_HIGH, 3'h0, 2'h1, 32'h00000000);
      rx(IDX_WINDOW_HIGH, HSIZE_WORD, 2'h2, 32'h00000000);
      rc(IDX_WINDOW_LOW, 32'h00000000);
      chk({31'h00000000, hresp}, 32'h00000000);
      rc(IDX_WINDOW_HIGH, qv(1, 0));
      rc(IDX_LINE_COUNT, 32'h00000006);
      secure_pin <= 1'b1;
      repeat (3) @(posedge hclk);
      rc(IDX_WINDOW_HIGH, 32'h00000000);
      secure_pin <= 1'b0;
      repeat (3) @(posedge hclk);
      rc(IDX_WINDOW_HIGH, qv(1, 1));
      wr(IDX_TRACE_CTRL, 32'h00000000);
      rc(IDX_WINDOW_HIGH, 32'h00000000);
      // the other reset must keep count and memory; control bits are lost
      sys_reset_req <= 1'b1;
      @(posedge hclk);
      sys_reset_req <= 1'b0;
      @(posedge hclk);
      rc(IDX_LINE_COUNT, 32'h00000006);
      wr(IDX_TRACE_CTRL, 32'h00000042);
      wr(IDX_WINDOW_HIGH, 32'h00000000);
      rc(IDX_WINDOW_HIGH, qv(0, 0));
      rc(IDX_WINDOW_HIGH, qv(0, 1));
      wr(IDX_FIRST_CTRL, 32'h00000080);
      rc(IDX_LINE_COUNT, 32'h00000000);
      push(0, 64);
      rc(IDX_LINE_COUNT, 32'h00000000);
      rc(IDX_STATUS, 32'h00000080);
      chk({31'h00000000, armed}, 32'h00000001);
      chk({31'h00000000, full}, 32'h00000001);
      push(64, 1);
      rc(IDX_LINE_COUNT, 32'h00000002);
      wr(IDX_FIRST_CTRL, 32'h00000000);
      wr(IDX_WINDOW_HIGH, 32'h00000000);
      rc(IDX_WINDOW_HIGH, qv(1, 0));
      wr(IDX_FIRST_CTRL, 32'h00000080);
      rc(IDX_STATUS, 32'h00000000);
      wr(IDX_FIRST_CTRL, 32'h00000000);
      wr(IDX_TRACE_CTRL, 32'h00000041);
      wr(IDX_FIRST_CTRL, 32'h00000080);
      push(0, 64);
      chk({31'h00000000, armed}, 32'h00000000);
      rc(IDX_STATUS, 32'h00000080);
      // power-on after a finished begin-aligned run must drop the full flag
      hresetn <= 1'b0;
      @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rc(IDX_STATUS, 32'h00000000);
      rc(IDX_LINE_COUNT, 32'h00000000);
      for (int b = 0; b < 3; b++) begin
         wr(IDX_FIRST_CTRL, 32'(b));
         wr(IDX_BANKED, 32'h00000005 + 32'(b));
      end
      for (int b = 0; b < 3; b++) begin
         wr(IDX_FIRST_CTRL, 32'(b));
         rc(IDX_BANKED, 32'h00000005 + 32'(b));
      end
      chk({28'h0000000, sc1}, 32'h00000005);
      chk({28'h0000000, sc2}, 32'h00000006);
      chk({28'h0000000, sc3}, 32'h00000007);
      wr(IDX_FIRST_CTRL, 32'h00000003);
      rc(IDX_BANKED, 32'h00000009);
      final_report();
   end
endmodule // tbr_readout_tb
`default_nettype wire
